// ==== rtl/smc_pkg.sv ====
// Functional notes
// - Clock select to subsystem only while running.
// - HALT instruction stops CPU clock and execution.
// - Oscillators running before HALT keep oscillating.
// - Interrupt in HALT resumes at once, no wait.
// - HALT keeps CPU registers, RAM, port states.
// - RAM reachable in HALT during data transfers.
// - STOP instruction halts both high-speed oscillators.
// - Interrupt request releases STOP mode.
// - Crystal clock selected: stabilization wait after STOP.
// - SNOOZE events leave STOP without running CPU.
// - SNOOZE only with on-chip oscillator as fclk.
// - Async serial SNOOZE only if select bit4 zero.
// - Subsystem clock disables ADC, I2C, CRC.
// - STOP keeps subsystem oscillator, ports, RAM.
// - Listed always-on functions keep running in STOP.
// - Partially operable functions in STOP as conditioned.
// - Timer array, timers RD and RG, and guards stopped during STOP.
package smc_pkg;

    // Clock rate
    localparam int CLK_PERIOD_NS = 8;
    // Oscillation stabilization time, plain default
    localparam int STAB_TIME_NS  = 102400;
    // Least time rounds up to whole cycles
    localparam int STAB_CYCLES   =
        (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_CNT_W    = 16;

    // Standby state, one-hot
    typedef enum logic [4:0] {
        SMC_RUN    = 5'h01,
        SMC_HALT   = 5'h02,
        SMC_STOP   = 5'h04,
        SMC_STAB   = 5'h08,
        SMC_SNOOZE = 5'h10
    } smc_mode_t;

    // Oscillator enables or status
    typedef struct packed {
        logic highSpeedSys;   // Main system oscillator
        logic onChipHs;       // High-speed on-chip oscillator
        logic subsystem;      // Subsystem oscillator
    } smc_osc_t;

    // Reset value of oscillator enables
    localparam smc_osc_t OSC_RST = 3'h2;

    // SNOOZE wake sources
    typedef struct packed {
        logic clockedSerialRx;          // clocked_serial_channel
        logic asyncSerialRx;            // async_serial_channel
        logic rtcIntReq;                // rtc_interrupt_request
        logic intervalTimerIntReq;      // interval_timer_interrupt_request
        logic eventLinkIn;              // event_link_unit trigger
        logic dataXferStart;            // data_transfer_controller source
    } smc_wake_t;

    // Static configuration bits
    typedef struct packed {
        logic snoozeEn;         // SNOOZE requested by software
        logic oscFreqSelBit4;   // osc_frequency_select_bit4
        logic fclkOnChip;       // fclk is on-chip oscillator
        logic mainCrystalClock; // main_crystal_clock is main source
        logic wdtRunInStop;     // Watchdog keeps running in STOP
        logic cmpNoFilter;      // Comparator digital filter unused
        logic cmpExtRef;        // Comparator external reference
    } smc_cfg_t;

    // Peripheral clock enables
    typedef struct packed {
        logic adc;
        logic i2cSerial;
        logic crcHs;
        logic serialArray;
        logic dataXfer;
        logic timerArray;
        logic timerRd;
        logic timerRg;
        logic rtc;
        logic intervalTimer;
        logic watchdog;
        logic timerRj;
        logic clkBuzzer;
        logic dac;
        logic eventLink;
        logic comparator;
        logic keyInt;
        logic voltDetect;
        logic powerOnReset;
        logic crcOp;
        logic illegalAccess;
        logic ramGuard;
        logic sfrGuard;
    } smc_periph_t;

    // Registered outputs of the controller
    typedef struct packed {
        logic        cpuClkEn;
        logic        cpuClkSub;
        smc_osc_t    oscEn;
        smc_periph_t periphEn;
        logic        ramClkEn;
        logic        stateHold;
        logic        i2cAddrWake;
        logic        dataXferSrcOnly;
    } smc_out_t;

endpackage

// ==== rtl/smc_stab_timer.sv ====
// Oscillation stabilization counter
module smc_stab_timer #(
    parameter int CYCLES = smc_pkg::STAB_CYCLES,
    parameter int WIDTH  = smc_pkg::STAB_CNT_W
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic start,
    input  wire logic abort,
    // Status
    output logic      busy,
    output logic      done
);
    import smc_pkg::*;

    // Whole timer state
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             busy;
        logic             done;
    } smc_tmr_t;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES - 1);

    smc_tmr_t tmr_q;  // Registered state
    smc_tmr_t tmr_d;  // Next state

    // Count down the wait, done pulses once at the end
    always_comb begin
        tmr_d      = tmr_q;
        tmr_d.done = 1'b0;
        if (abort) begin
            tmr_d.busy = 1'b0;
        end else if (start) begin
            // Restart reloads the full wait unless abort is set in the same cycle
            tmr_d.busy = 1'b1;
            tmr_d.cnt  = LAST;
        end else if (tmr_q.busy) begin
            if (tmr_q.cnt == '0) begin
                tmr_d.busy = 1'b0;
                tmr_d.done = 1'b1;
            end else begin
                tmr_d.cnt = tmr_q.cnt - WIDTH'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    assign busy = tmr_q.busy;
    assign done = tmr_q.done;

endmodule

// ==== rtl/smc_standby_ctrl.sv ====
// Standby mode controller: HALT, STOP, SNOOZE and clock select
module smc_standby_ctrl #(
    parameter int STAB_WAIT = smc_pkg::STAB_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // CPU core requests
    input  wire logic                 haltExec,
    input  wire logic                 stopExec,
    input  wire logic                 clkSrcWrite,
    input  wire logic                 clkSrcData,
    // Wake and activity sources
    input  wire logic                 intReq,
    input  wire logic                 dataXferBusy,
    input  wire smc_pkg::smc_wake_t   wakeReq,
    input  wire logic                 snoozeDone,
    // Configuration and oscillator control
    input  wire smc_pkg::smc_cfg_t    cfg,
    input  wire smc_pkg::smc_osc_t    oscReq,
    input  wire smc_pkg::smc_osc_t    oscRunning,
    // Mode status
    output smc_pkg::smc_mode_t        mode,
    output smc_pkg::smc_wake_t        snoozeSrc,
    output logic                      stabBusy,
    // Clock gating
    output logic                      cpuClkEn,
    output logic                      cpuClkSub,
    output smc_pkg::smc_osc_t         oscEn,
    output smc_pkg::smc_periph_t      periphEn,
    output logic                      ramClkEn,
    output logic                      stateHold,
    output logic                      i2cAddrWake,
    output logic                      dataXferSrcOnly
);
    import smc_pkg::*;

    // Whole controller state
    typedef struct packed {
        smc_mode_t mode;
        logic      clkSub;     // cpu_clock_source_select
        smc_osc_t  oscSnap;    // Oscillators requested at entry
        smc_wake_t snoozeSrc;  // Event that opened SNOOZE
        smc_out_t  out;        // Registered outputs
    } smc_state_t;

    // Reset value of the whole state
    localparam smc_state_t STATE_RST = '{
        mode:      SMC_RUN,
        clkSub:    1'b0,
        oscSnap:   OSC_RST,
        snoozeSrc: '0,
        out:       '{cpuClkEn: 1'b1, cpuClkSub: 1'b0, oscEn: OSC_RST,
                     periphEn: '1, ramClkEn: 1'b1, stateHold: 1'b0,
                     i2cAddrWake: 1'b0, dataXferSrcOnly: 1'b0}
    };

    smc_state_t st_q;   // Registered state
    smc_state_t st_d;   // Next state

    logic stabStart;    // Load the stabilization wait
    logic stabDone;     // Wait elapsed, one cycle
    logic stabAbort;    // Cancel wait

    // Filter wake events by what SNOOZE may accept
    function automatic smc_wake_t snoozeFilter(input smc_wake_t w,
                                               input smc_cfg_t  c);
        smc_wake_t f;
        f = w;
        // Async serial only with low frequency select
        if (c.oscFreqSelBit4) begin
            f.asyncSerialRx = 1'b0;
        end
        // Nothing wakes into SNOOZE unless enabled on on-chip fclk
        if (!c.snoozeEn || !c.fclkOnChip) begin
            f = '0;
        end
        return f;
    endfunction

    // Peripheral clocks allowed in a given mode
    function automatic smc_periph_t periphGate(input smc_mode_t m,
                                               input logic      sub,
                                               input smc_cfg_t  c);
        smc_periph_t p;
        p = '1;
        // Subsystem clock: ADC, I2C and fast CRC disabled
        if (sub) begin
            p.adc       = 1'b0;
            p.i2cSerial = 1'b0;
            p.crcHs     = 1'b0;
        end
        if (m == SMC_STOP || m == SMC_SNOOZE) begin
            // Always-on group keeps its clock; watchdog only with wdtRunInStop
            p.rtc           = 1'b1;
            p.intervalTimer = 1'b1;
            p.timerRj       = 1'b1;
            p.clkBuzzer     = 1'b1;
            p.dac           = 1'b1;
            p.eventLink     = 1'b1;
            p.keyInt        = 1'b1;
            p.voltDetect    = 1'b1;
            p.powerOnReset  = 1'b1;
            p.watchdog      = c.wdtRunInStop;
            // Partial group
            p.adc         = (m == SMC_SNOOZE);
            p.serialArray = (m == SMC_SNOOZE);
            p.comparator  = c.cmpNoFilter && c.cmpExtRef;
            p.i2cSerial   = 1'b0;
            p.dataXfer    = (m == SMC_SNOOZE);
            p.crcHs       = 1'b0;
            // Disabled timers and stopped checkers
            p.timerArray    = 1'b0;
            p.timerRd       = 1'b0;
            p.timerRg       = 1'b0;
            p.crcOp         = 1'b0;
            p.illegalAccess = 1'b0;
            p.ramGuard      = 1'b0;
            p.sfrGuard      = 1'b0;
        end
        return p;
    endfunction

    // Mode sequencing and output decode
    always_comb begin
        smc_wake_t accepted;
        accepted  = snoozeFilter(wakeReq, cfg);
        st_d      = st_q;
        stabStart = 1'b0;
        stabAbort = 1'b0;

        unique case (st_q.mode)
            SMC_RUN: begin
                // Switch to subsystem only if it oscillates
                if (clkSrcWrite) begin
                    if (!clkSrcData) begin
                        st_d.clkSub = 1'b0;
                    end else if (oscRunning.subsystem) begin
                        st_d.clkSub = 1'b1;
                    end
                end
                // STOP wins when both instructions arrive together
                if (stopExec) begin
                    st_d.mode    = SMC_STOP;
                    st_d.oscSnap = oscReq;
                end else if (haltExec) begin
                    st_d.mode    = SMC_HALT;
                    st_d.oscSnap = oscReq;
                end
            end
            SMC_HALT: begin
                // Clocks still run, so no wait on wake
                if (intReq) begin
                    st_d.mode = SMC_RUN;
                end
            end
            SMC_STOP: begin
                if (intReq) begin
                    // Crystal needs to settle before the CPU runs
                    if (cfg.mainCrystalClock && !st_q.clkSub) begin
                        st_d.mode = SMC_STAB;
                        stabStart = 1'b1;
                    end else begin
                        st_d.mode = SMC_RUN;
                    end
                end else if (accepted != '0) begin
                    st_d.mode      = SMC_SNOOZE;
                    st_d.snoozeSrc = accepted;
                end
            end
            SMC_SNOOZE: begin
                // Interrupt ends the service; fclk is on-chip, no wait
                if (intReq) begin
                    st_d.mode      = SMC_RUN;
                    st_d.snoozeSrc = '0;
                end else if (snoozeDone) begin
                    st_d.mode      = SMC_STOP;
                    st_d.snoozeSrc = '0;
                end
            end
            SMC_STAB: begin
                if (stabDone) begin
                    st_d.mode = SMC_RUN;
                end
            end
            default: begin
                // Illegal code recovers to normal run
                st_d.mode = SMC_RUN;
                stabAbort = 1'b1;
            end
        endcase

        // Output decode from the next state
        st_d.out.cpuClkSub = st_d.clkSub;
        st_d.out.cpuClkEn  = (st_d.mode == SMC_RUN);
        st_d.out.periphEn  = periphGate(st_d.mode, st_d.clkSub, cfg);
        st_d.out.stateHold = (st_d.mode != SMC_RUN);
        // RAM kept; clocked for transfers in HALT and SNOOZE
        st_d.out.ramClkEn  = (st_d.mode == SMC_RUN)
                          || (st_d.mode == SMC_SNOOZE)
                          || (st_d.mode == SMC_HALT
                              && dataXferBusy);
        st_d.out.i2cAddrWake     = (st_d.mode == SMC_STOP);
        st_d.out.dataXferSrcOnly = (st_d.mode == SMC_STOP);

        unique case (st_d.mode)
            SMC_HALT: begin
                // Frozen at entry so nothing stops during HALT
                st_d.out.oscEn = st_q.mode == SMC_RUN
                               ? oscReq : st_q.oscSnap;
            end
            SMC_STOP: begin
                st_d.out.oscEn              = '0;
                st_d.out.oscEn.subsystem    =
                    st_d.oscSnap.subsystem;
            end
            SMC_SNOOZE: begin
                // Service runs on the on-chip oscillator
                st_d.out.oscEn              = '0;
                st_d.out.oscEn.onChipHs     = 1'b1;
                st_d.out.oscEn.subsystem    = st_q.oscSnap.subsystem;
            end
            SMC_STAB: begin
                st_d.out.oscEn              = st_q.oscSnap;
                st_d.out.oscEn.highSpeedSys = 1'b1;
            end
            default: begin
                st_d.out.oscEn = oscReq;
            end
        endcase
    end

    // State register; reset ends any standby mode
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Stabilization wait
    smc_stab_timer #(
        .CYCLES (STAB_WAIT),
        .WIDTH  (STAB_CNT_W)
    ) u_stab (
        .clk   (clk),
        .srst  (srst),
        .start (stabStart),
        .abort (stabAbort),
        .busy  (stabBusy),
        .done  (stabDone)
    );

    // Outputs straight from the state register
    assign mode            = st_q.mode;
    assign snoozeSrc       = st_q.snoozeSrc;
    assign cpuClkEn        = st_q.out.cpuClkEn;
    assign cpuClkSub       = st_q.out.cpuClkSub;
    assign oscEn           = st_q.out.oscEn;
    assign periphEn        = st_q.out.periphEn;
    assign ramClkEn        = st_q.out.ramClkEn;
    assign stateHold       = st_q.out.stateHold;
    assign i2cAddrWake     = st_q.out.i2cAddrWake;
    assign dataXferSrcOnly = st_q.out.dataXferSrcOnly;

endmodule

// ==== verif/smc_cpu_model.sv ====
// CPU core and interrupt source in front of the controller
module smc_cpu_model (
    // Clock
    input  wire logic clk,
    // Instruction and write strobes
    output logic      haltExec,
    output logic      stopExec,
    output logic      clkSrcWrite,
    output logic      clkSrcData,
    // Interrupt request level
    output logic      intReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet at time zero
    initial begin
        haltExec = 1'b0;
        stopExec = 1'b0;
        clkSrcWrite = 1'b0;
        clkSrcData = 1'b0;
        intReq = 1'b0;
    end
    // One-cycle instruction strobe, taken at the second edge
    task automatic instr(input logic h, input logic s);
        @(posedge clk);
        haltExec <= h;
        stopExec <= s;
        @(posedge clk);
        haltExec <= 1'b0;
        stopExec <= 1'b0;
        #1;
    endtask
    // Select write; data inverted after so a stale value never helps
    task automatic clkSel(input logic v);
        @(posedge clk);
        clkSrcWrite <= 1'b1;
        clkSrcData <= v;
        @(posedge clk);
        clkSrcWrite <= 1'b0;
        clkSrcData <= ~v;
        #1;
    endtask
    // Interrupt level, raised or dropped after an edge
    task automatic irq(input logic v);
        @(posedge clk);
        intReq <= v;
        #1;
    endtask
endmodule

// ==== verif/smc_standby_chk.sv ====
// Port-level checks of the standby controller
module smc_standby_chk #(
    parameter int STAB_WAIT = 8
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 srst,
    // Requests and configuration
    input wire logic                 haltExec,
    input wire logic                 stopExec,
    input wire logic                 clkSrcWrite,
    input wire logic                 clkSrcData,
    input wire logic                 intReq,
    input wire logic                 dataXferBusy,
    input wire smc_pkg::smc_wake_t   wakeReq,
    input wire smc_pkg::smc_cfg_t    cfg,
    input wire smc_pkg::smc_osc_t    oscReq,
    input wire smc_pkg::smc_osc_t    oscRunning,
    // Watched outputs
    input wire smc_pkg::smc_mode_t   mode,
    input wire logic                 stabBusy,
    input wire logic                 cpuClkEn,
    input wire logic                 cpuClkSub,
    input wire smc_pkg::smc_osc_t    oscEn,
    input wire smc_pkg::smc_periph_t periphEn,
    input wire logic                 ramClkEn,
    input wire logic                 stateHold
);
    import smc_pkg::*;
    logic [15:0] stabCnt_q; // Sampled cycles spent in the wait
    logic [5:0]  wakeOk;    // Wake sources the settings let through
    // Async serial source drops out when bit4 is set
    always_comb begin
        wakeOk = 6'h00;
        if (cfg.snoozeEn && cfg.fclkOnChip) begin
            wakeOk = cfg.oscFreqSelBit4 ? 6'h2F : 6'h3F;
        end
    end
    // Wait length counter, cleared outside the wait
    always_ff @(posedge clk) begin
        if (srst || mode != SMC_STAB) begin
            stabCnt_q <= 16'h0000;
        end else begin
            stabCnt_q <= stabCnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    clk_select_a: assert property (
        mode == SMC_RUN && clkSrcWrite && clkSrcData && !haltExec
        && !stopExec && oscRunning.subsystem |=> cpuClkSub && mode == SMC_RUN)
        else $error("clock select not taken");
    halt_entry_a: assert property (
        mode == SMC_RUN && haltExec && !stopExec
        |=> mode == SMC_HALT && !cpuClkEn && oscEn == $past(oscReq))
        else $error("halt entry wrong");
    halt_osc_a: assert property (
        mode == SMC_HALT && $past(mode) == SMC_HALT |-> $stable(oscEn))
        else $error("oscillators changed in halt");
    halt_wake_a: assert property (
        mode == SMC_HALT && intReq |=> mode == SMC_RUN && cpuClkEn)
        else $error("halt wake not immediate");
    halt_keep_a: assert property (
        mode == SMC_HALT && $past(mode) == SMC_HALT && $past(dataXferBusy)
        |-> stateHold && ramClkEn)
        else $error("halt retention or ram clock lost");
    stop_entry_a: assert property (
        mode == SMC_RUN && stopExec |=> mode == SMC_STOP && stateHold
        && !oscEn.highSpeedSys && !oscEn.onChipHs)
        else $error("stop entry wrong");
    stop_wake_a: assert property (
        mode == SMC_STOP && intReq && !(cfg.mainCrystalClock && !cpuClkSub)
        |=> mode == SMC_RUN)
        else $error("stop wake missing");
    stop_stab_a: assert property (
        mode == SMC_STOP && intReq && cfg.mainCrystalClock && !cpuClkSub
        |=> mode == SMC_STAB ##1 stabBusy)
        else $error("stabilization wait skipped");
    stab_len_a: assert property (
        mode == SMC_RUN && $past(mode) == SMC_STAB && !$past(srst)
        |-> stabCnt_q == 16'(STAB_WAIT + 1))
        else $error("stabilization wait length wrong");
    snooze_in_a: assert property (
        mode == SMC_STOP && !intReq && (wakeReq & wakeOk) != 6'h00
        |=> mode == SMC_SNOOZE && !cpuClkEn)
        else $error("snooze entry missing");
    snooze_no_a: assert property (
        mode == SMC_STOP && !intReq && (wakeReq & wakeOk) == 6'h00
        |=> mode == SMC_STOP)
        else $error("refused source left stop");
    sub_periph_a: assert property (
        cpuClkSub && (mode == SMC_RUN || mode == SMC_HALT)
        |-> !periphEn.adc && !periphEn.i2cSerial && !periphEn.crcHs)
        else $error("peripheral enabled on subsystem clock");
    stop_periph_a: assert property (
        mode == SMC_STOP |-> periphEn.rtc && periphEn.intervalTimer
        && !periphEn.timerArray && !periphEn.timerRd && !periphEn.timerRg
        && !periphEn.crcOp && !periphEn.sfrGuard)
        else $error("peripheral enables wrong in stop");
endmodule

bind smc_standby_ctrl smc_standby_chk #(.STAB_WAIT(STAB_WAIT)) i_smc_chk (
    .clk(clk), .srst(srst), .haltExec(haltExec), .stopExec(stopExec),
    .clkSrcWrite(clkSrcWrite), .clkSrcData(clkSrcData), .intReq(intReq),
    .dataXferBusy(dataXferBusy), .wakeReq(wakeReq), .cfg(cfg),
    .oscReq(oscReq), .oscRunning(oscRunning), .mode(mode),
    .stabBusy(stabBusy), .cpuClkEn(cpuClkEn), .cpuClkSub(cpuClkSub),
    .oscEn(oscEn), .periphEn(periphEn), .ramClkEn(ramClkEn),
    .stateHold(stateHold));

// ==== verif/test_standby_mode_controller.sv ====
// Directed sequences over halt, stop, snooze and clock select
module test_standby_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import smc_pkg::*;
    localparam int SW = 8; // Shortened stabilization wait
    logic        clk, srst, dataXferBusy, snoozeDone;
    logic        haltExec, stopExec, clkSrcWrite, clkSrcData, intReq;
    logic        stabBusy, cpuClkEn, cpuClkSub, ramClkEn, stateHold;
    logic        i2cAddrWake, dataXferSrcOnly;
    smc_wake_t   wakeReq, snoozeSrc;
    smc_cfg_t    cfg;
    smc_osc_t    oscReq, oscRunning, oscEn;
    smc_mode_t   mode;
    smc_periph_t periphEn;
    int          errors, tests_run, n;
    smc_standby_ctrl #(.STAB_WAIT(SW)) i_smc_standby_ctrl (
        .clk(clk), .srst(srst), .haltExec(haltExec), .stopExec(stopExec),
        .clkSrcWrite(clkSrcWrite), .clkSrcData(clkSrcData),
        .intReq(intReq), .dataXferBusy(dataXferBusy), .wakeReq(wakeReq),
        .snoozeDone(snoozeDone), .cfg(cfg), .oscReq(oscReq),
        .oscRunning(oscRunning), .mode(mode), .snoozeSrc(snoozeSrc),
        .stabBusy(stabBusy), .cpuClkEn(cpuClkEn), .cpuClkSub(cpuClkSub),
        .oscEn(oscEn), .periphEn(periphEn), .ramClkEn(ramClkEn),
        .stateHold(stateHold), .i2cAddrWake(i2cAddrWake),
        .dataXferSrcOnly(dataXferSrcOnly));
    smc_cpu_model i_smc_cpu_model (
        .clk(clk), .haltExec(haltExec), .stopExec(stopExec),
        .clkSrcWrite(clkSrcWrite), .clkSrcData(clkSrcData),
        .intReq(intReq));
    // Free-running clock
    always #4 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle pulse of done and wake sources
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        {snoozeDone, wakeReq} <= v;
        @(posedge clk);
        {snoozeDone, wakeReq} <= 7'h00;
        #1;
    endtask
    // Advance edges, then let outputs settle
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic give_verdict;
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, far beyond the hundred or so cycles used
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        dataXferBusy = 1'b0;
        {snoozeDone, wakeReq} = 7'h00;
        cfg = 7'h57;
        oscReq = 3'h7;
        oscRunning = 3'h6;
        errors = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({mode, cpuClkEn, cpuClkSub, oscEn, stateHold}, 11'h064);
        chk({periphEn, snoozeSrc, stabBusy}, 30'h3FFFFF80);
        // Subsystem not yet running: select refused
        i_smc_cpu_model.clkSel(1'b1);
        chk(cpuClkSub, 1'b0);
        @(posedge clk);
        oscRunning <= 3'h7;
        oscReq <= 3'h3;
        i_smc_cpu_model.clkSel(1'b1);
        chk({mode, cpuClkSub}, {SMC_RUN, 1'b1});
        chk({periphEn.adc, periphEn.i2cSerial, periphEn.crcHs}, 3'h0);
        i_smc_cpu_model.instr(1'b1, 1'b0);
        chk({periphEn.adc, periphEn.i2cSerial, periphEn.crcHs}, 3'h0);
        // Request changes inside HALT must not reach the oscillators
        oscReq <= 3'h7;
        step(2);
        chk(oscEn, 3'h3);
        i_smc_cpu_model.irq(1'b1);
        i_smc_cpu_model.irq(1'b0);
        i_smc_cpu_model.clkSel(1'b0);
        chk(cpuClkSub, 1'b0);
        // Halt with a transfer running, stop refused inside it
        i_smc_cpu_model.instr(1'b1, 1'b0);
        chk({mode, cpuClkEn, stateHold}, {SMC_HALT, 2'b01});
        chk(oscEn, 3'h7);
        @(posedge clk);
        dataXferBusy <= 1'b1;
        step(2);
        chk(ramClkEn, 1'b1);
        i_smc_cpu_model.instr(1'b0, 1'b1);
        chk(mode, SMC_HALT);
        dataXferBusy <= 1'b0;
        i_smc_cpu_model.irq(1'b1);
        step(1);
        chk({mode, cpuClkEn}, {SMC_RUN, 1'b1});
        i_smc_cpu_model.irq(1'b0);
        // Stop wins over halt in the same cycle
        i_smc_cpu_model.instr(1'b1, 1'b1);
        chk({mode, oscEn, stateHold}, {SMC_STOP, 4'h3});
        chk({periphEn.timerArray, periphEn.timerRd, periphEn.timerRg,
             periphEn.crcOp, periphEn.illegalAccess, periphEn.ramGuard,
             periphEn.sfrGuard}, 7'h00);
        chk({periphEn.rtc, periphEn.intervalTimer, periphEn.watchdog,
             periphEn.timerRj, periphEn.clkBuzzer, periphEn.dac,
             periphEn.eventLink, periphEn.powerOnReset, periphEn.voltDetect,
             periphEn.keyInt}, 10'h3FF);
        chk({periphEn.comparator, i2cAddrWake, dataXferSrcOnly, periphEn.adc,
             periphEn.serialArray}, 5'h1C);
        // Every wake source in turn, then back to stop
        for (int i = 0; i < 6; i++) begin
            pulse({1'b0, 6'h01 << i});
            chk({mode, cpuClkEn, snoozeSrc}, {SMC_SNOOZE, 1'b0, 6'h01 << i});
            chk({periphEn.adc, periphEn.serialArray, oscEn.onChipHs},
                3'h7);
            pulse(7'h40);
            chk(mode, SMC_STOP);
        end
        @(posedge clk);
        cfg.oscFreqSelBit4 <= 1'b1;
        pulse(7'h10);
        chk(mode, SMC_STOP);
        @(posedge clk);
        cfg.snoozeEn <= 1'b0;
        pulse(7'h3F);
        chk(mode, SMC_STOP);
        @(posedge clk);
        cfg.snoozeEn <= 1'b1;
        cfg.fclkOnChip <= 1'b0;
        pulse(7'h3F);
        chk(mode, SMC_STOP);
        i_smc_cpu_model.irq(1'b1);
        step(1);
        chk(mode, SMC_RUN);
        i_smc_cpu_model.irq(1'b0);
        // Crystal selected: wake goes through the wait
        @(posedge clk);
        cfg <= 7'h58;
        i_smc_cpu_model.instr(1'b0, 1'b1);
        chk({periphEn.watchdog, periphEn.comparator}, 2'b00);
        i_smc_cpu_model.irq(1'b1);
        step(1);
        chk(mode, SMC_STAB);
        step(1);
        chk(stabBusy, 1'b1);
        n = 1;
        while (mode !== SMC_RUN && n < 50) begin
            step(1);
            n++;
        end
        chk(n, SW + 1);
        i_smc_cpu_model.irq(1'b0);
        // Reset in the middle of stop
        i_smc_cpu_model.instr(1'b0, 1'b1);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({mode, cpuClkEn, stateHold, oscEn}, {SMC_RUN, 2'b10, 3'h2});
        give_verdict();
    end
endmodule
